// [verilog/sram_port_params.svh]
// Constants for the pipelined burst memory port: widths, strap and timing counts.
// Assumes inclusion by bare name from the package, burst_seq and sram_port.
`ifndef SRAM_PORT_PARAMS_SVH
`define SRAM_PORT_PARAMS_SVH
`define ADDR_W        18
`define LANES         4
`define LANE_W        8
`define BURST_W       2
`define MODE_LINEAR   1'b0
`define MODE_INTERLV  1'b1
`define SLEEP_CYCLES  2
`define PARAM_CLK_MHZ 125
`endif

// [verilog/sram_port_pkg.sv]
// Types shared by the memory port modules.
// Assumes the params header is on the include path.
`include "sram_port_params.svh"
package sram_port_pkg;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} access_t;
  typedef struct packed {
    logic                chip_select_first_n;
    logic                chip_select_second;
    logic                chip_select_third_n;
    logic                advance_or_load;
    logic                write_n;
    logic [`LANES-1:0]   byte_write_sel_n;
    logic [`ADDR_W-1:0]  addr;
  } cmd_t;
  typedef struct packed {
    logic                    oe;
    logic [`LANES*`LANE_W-1:0] dq;
    logic [`LANES-1:0]       par;
  } lane_out_t;
endpackage

// [verilog/burst_seq.sv]
// Burst address step: next two low address bits for interleaved or linear order.
// Assumes the caller holds the start value and a beat index.
`timescale 1ns/10ps
`include "sram_port_params.svh"
module burst_seq
(
  // Burst state
  input  wire logic [`BURST_W-1:0] start,
  input  wire logic [`BURST_W-1:0] beat,
  input  wire logic                order,
  // Result
  output      logic [`BURST_W-1:0] low_addr
);
  always_comb
  begin
    if (order == `MODE_INTERLV)
      low_addr = start ^ beat;
    else
      low_addr = start + beat;
  end
endmodule

// [verilog/sram_array.sv]
// Byte-lane memory array with self-timed synchronous write and registered read.
// Assumes the caller qualifies every access with the clock enable.
`timescale 1ns/10ps
module sram_array #(
  parameter int ADDR_W = 18,
  parameter int LANES  = 4,
  parameter int LANE_W = 9
)
(
  // Clock
  input  wire logic                    clk,
  input  wire logic                    ce,
  // Write port
  input  wire logic                    wr,
  input  wire logic [LANES-1:0]        wr_lane,
  input  wire logic [ADDR_W-1:0]       wr_addr,
  input  wire logic [LANES*LANE_W-1:0] wr_data,
  // Read port
  input  wire logic [ADDR_W-1:0]       rd_addr,
  output      logic [LANES*LANE_W-1:0] rd_data
);
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      // Each lane keeps its own array, so every array has exactly one writer.
      logic [LANE_W-1:0] mem [0:(1<<ADDR_W)-1];
      always_ff @(posedge clk)
      begin
        if (ce && wr && wr_lane[g])
          mem[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
        if (ce)
          rd_data[g*LANE_W +: LANE_W] <= mem[rd_addr];
      end
    end
  endgenerate
endmodule

// [verilog/sram_port.sv]
// Device-side model of a pipelined burst memory port with a scan bypass path.
// Assumes all inputs are synchronous to clk except the test port pins on test_clk.
`timescale 1ns/10ps
`include "sram_port_params.svh"
module sram_port #(
  parameter int ADDR_W = `ADDR_W,
  parameter int LANES  = `LANES,
  parameter int LANE_W = `LANE_W
)
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    clock_qualify_n,
  // Command
  input  wire logic                    chip_select_first_n,
  input  wire logic                    chip_select_second,
  input  wire logic                    chip_select_third_n,
  input  wire logic                    advance_or_load,
  input  wire logic                    write_n,
  input  wire logic [LANES-1:0]        byte_write_sel_n,
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic                    output_enable_n,
  input  wire logic                    burst_mode,
  input  wire logic                    sleep_request,
  // Data lanes
  input  wire logic [LANES*LANE_W-1:0] dq_in,
  input  wire logic [LANES-1:0]        parity_lanes_in,
  output      logic [LANES*LANE_W-1:0] dq_out,
  output      logic [LANES-1:0]        parity_lanes_out,
  output      logic                    dq_oe,
  // Status
  output      logic                    sleeping,
  // Test port
  input  wire logic                    test_clk,
  input  wire logic                    test_mode_sel,
  input  wire logic                    test_data_in,
  output      logic                    test_data_out,
  output      logic                    test_mode_q
);
  localparam int W = LANE_W + 1;
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    sram_port_pkg::access_t   acc;
    sram_port_pkg::access_t   phase;
    logic                     was_desel;
    logic [ADDR_W-1:0]        base;
    logic [1:0]               beat;
    logic                     order;
    logic [ADDR_W-1:0]        wr_addr;
    logic [LANES-1:0]         wr_lane;
    logic [ADDR_W-1:0]        pend_addr;
    logic [LANES-1:0]         pend_lane;
    logic                     wr_go;
    logic [LANES*W-1:0]       wr_data;
    logic [1:0]               sleep_cnt;
    logic                     sleep;
    logic                     oe_pre;
    logic                     oe_int;
    logic                     oe_hold;
    logic [LANES*LANE_W-1:0]  dq;
    logic [LANES-1:0]         par;
  } state_t;
  state_t s_q, s_d;
  sram_port_pkg::cmd_t cmd_q;
  logic                ce;
  logic [1:0]          low_addr;
  logic [ADDR_W-1:0]   cur_addr;
  logic [LANES*W-1:0]  rd_word;
  function automatic logic selected(input sram_port_pkg::cmd_t c);
    selected = !c.chip_select_first_n && c.chip_select_second && !c.chip_select_third_n;
  endfunction
  function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] step, input logic order);
    burst_low = (order == `MODE_INTERLV) ? (start ^ step) : (start + step);
  endfunction
  assign ce = !clock_qualify_n && !s_q.sleep;
  // ****************************************************************
  // Input registers
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
      cmd_q <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, {LANES{1'b1}}, '0};
    else if (ce)
      cmd_q <= '{chip_select_first_n, chip_select_second, chip_select_third_n,
                 advance_or_load, write_n, byte_write_sel_n, addr};
  end
  burst_seq u_seq
  (
    .start    (s_q.base[1:0]),
    .beat     (s_q.beat),
    .order    (s_q.order),
    .low_addr (low_addr)
  );
  assign cur_addr = {s_q.base[ADDR_W-1:2], low_addr};
  sram_array #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(W)) u_array
  (
    .clk     (clk),
    .ce      (ce),
    .wr      (s_q.wr_go),
    .wr_lane (s_q.wr_lane),
    .wr_addr (s_q.wr_addr),
    .wr_data (s_q.wr_data),
    .rd_addr (cur_addr),
    .rd_data (rd_word)
  );
  // ****************************************************************
  // Control
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    // Sleep is sampled through two clocks so entry and exit take two cycles.
    if (sleep_request != s_q.sleep)
    begin
      s_d.sleep_cnt = s_q.sleep_cnt + 2'd1;
      if (s_q.sleep_cnt == 2'(`SLEEP_CYCLES - 1))
      begin
        s_d.sleep     = sleep_request;
        s_d.sleep_cnt = '0;
      end
    end
    else
      s_d.sleep_cnt = '0;
    if (ce)
    begin
      s_d.wr_go = 1'b0;
      s_d.order = burst_mode;
      if (!cmd_q.advance_or_load)
      begin
        if (selected(cmd_q))
        begin
          s_d.acc  = cmd_q.write_n ? sram_port_pkg::ST_READ : sram_port_pkg::ST_WRITE;
          s_d.base = cmd_q.addr;
          s_d.beat = 2'd0;
        end
        else
          s_d.acc = sram_port_pkg::ST_IDLE;
      end
      else if (s_q.acc != sram_port_pkg::ST_IDLE)
        s_d.beat = s_q.beat + 2'd1;
      s_d.phase     = s_d.acc;
      s_d.was_desel = (s_q.phase == sram_port_pkg::ST_IDLE);
      // Data phase of a write: capture lanes and fire the self-timed write.
      if (s_q.phase == sram_port_pkg::ST_WRITE)
      begin
        s_d.wr_go   = 1'b1;
        s_d.wr_addr = s_q.pend_addr;
        s_d.wr_lane = s_q.pend_lane;
        for (int i = 0; i < LANES; i++)
          s_d.wr_data[i*W +: W] = {parity_lanes_in[i], dq_in[i*LANE_W +: LANE_W]};
      end
      if (s_d.acc == sram_port_pkg::ST_WRITE)
      begin
        s_d.pend_addr = {s_d.base[ADDR_W-1:2], burst_low(s_d.base[1:0], s_d.beat, s_d.order)};
        s_d.pend_lane = ~cmd_q.byte_write_sel_n;
      end
      s_d.oe_pre  = (s_q.phase == sram_port_pkg::ST_READ) && !s_q.was_desel;
      s_d.oe_int  = s_q.oe_pre;
      s_d.oe_hold = s_q.oe_int;
      for (int i = 0; i < LANES; i++)
      begin
        s_d.dq[i*LANE_W +: LANE_W] = rd_word[i*W +: LANE_W];
        s_d.par[i]                 = rd_word[i*W + LANE_W];
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q           <= '0;
      s_q.order     <= `MODE_INTERLV;
      s_q.was_desel <= 1'b1;
    end
    else
      s_q <= s_d;
  end
  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The enable is registered per the output rule, so the asynchronous
  // enable reaches the pins one clock late; a trade against a glitch-free port.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dq_out           <= '0;
      parity_lanes_out <= '0;
      dq_oe            <= 1'b0;
      sleeping         <= 1'b0;
    end
    else
    begin
      // A stretched cycle holds the pins, so the enable falls back to the held drive state.
      if (ce)
      begin
        dq_out           <= s_q.dq;
        parity_lanes_out <= s_q.par;
      end
      dq_oe            <= (ce ? s_q.oe_int : s_q.oe_hold) && !output_enable_n;
      sleeping         <= s_q.sleep;
    end
  end
  // ****************************************************************
  // Test port bypass path
  // ****************************************************************
  logic bypass_q;
  always_ff @(posedge test_clk)
  begin
    bypass_q    <= test_data_in;
    test_mode_q <= test_mode_sel;
  end
  always_ff @(negedge test_clk)
  begin
    test_data_out <= bypass_q;
  end
  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence load_sel_s;
    ce && !cmd_q.advance_or_load && selected(cmd_q);
  endsequence
  sequence wr_phase_s;
    ce && s_q.phase == sram_port_pkg::ST_WRITE;
  endsequence
  hold_state_a : assert property (@(posedge clk) disable iff (srst)
    (clock_qualify_n && !$past(srst)) |=> $stable(s_q.beat) && $stable(s_q.base))
    else $error("state moved while clock qualifier high");
  stretch_a : assert property (@(posedge clk) disable iff (srst)
    clock_qualify_n |=> s_q.acc == $past(s_q.acc))
    else $error("qualifier deselected the device");
  load_acc_a : assert property (@(posedge clk) disable iff (srst)
    load_sel_s |=> s_q.acc == ($past(cmd_q.write_n) ? sram_port_pkg::ST_READ : sram_port_pkg::ST_WRITE))
    else $error("access type wrong after load");
  wrap_a : assert property (@(posedge clk) disable iff (srst)
    (ce && cmd_q.advance_or_load && s_q.acc != sram_port_pkg::ST_IDLE) |=> s_q.beat == $past(s_q.beat) + 2'd1)
    else $error("burst counter did not step");
  float_wr_a : assert property (@(posedge clk) disable iff (srst)
    wr_phase_s |=> ##2 !dq_oe)
    else $error("lanes driven in write data phase");
  oe_mask_a : assert property (@(posedge clk) disable iff (srst)
    output_enable_n |=> !dq_oe)
    else $error("lanes driven with output enable high");
  desel_pipe_a : assert property (@(posedge clk) disable iff (srst)
    (ce && !cmd_q.advance_or_load && !selected(cmd_q)) |=> s_q.phase == sram_port_pkg::ST_IDLE)
    else $error("deselect not pipelined");
  wr_fire_a : assert property (@(posedge clk) disable iff (srst)
    wr_phase_s |=> s_q.wr_go)
    else $error("write not fired in data phase");
  load_addr_a : assert property (@(posedge clk) disable iff (srst)
    load_sel_s |=> s_q.base == $past(cmd_q.addr) && s_q.beat == 2'd0)
    else $error("load did not take the new address");
  cmd_reg_a : assert property (@(posedge clk) disable iff (srst)
    ce |=> cmd_q.addr == $past(addr) && cmd_q.byte_write_sel_n == $past(byte_write_sel_n))
    else $error("command pins not registered");
  order_a : assert property (@(posedge clk) disable iff (srst)
    ce |=> s_q.order == $past(burst_mode))
    else $error("burst order not taken from strap");
  freeze_out_a : assert property (@(posedge clk) disable iff (srst)
    clock_qualify_n |=> $stable(dq_out) && $stable(parity_lanes_out))
    else $error("output lanes moved while clock qualifier high");
  first_float_a : assert property (@(posedge clk) disable iff (srst)
    (ce && s_q.was_desel) |=> !s_q.oe_pre)
    else $error("lanes driven on first cycle after deselect");
  desel_float_a : assert property (@(posedge clk) disable iff (srst)
    (ce && s_q.phase == sram_port_pkg::ST_IDLE) |=> !s_q.oe_pre)
    else $error("lanes driven while deselected");
  lane_sel_a : assert property (@(posedge clk) disable iff (srst)
    wr_phase_s |=> s_q.wr_lane == $past(s_q.pend_lane))
    else $error("write lanes not taken from load cycle");
  rd_out_a : assert property (@(posedge clk) disable iff (srst)
    ce |=> dq_out == $past(s_q.dq) && parity_lanes_out == $past(s_q.par))
    else $error("read data skipped the output register");
endmodule

// [tb/ctrl_model.sv]
// Controller model: one command per qualified clock, write data two clocks later.
// Assumes the bench calls put from the falling edge of clk.
`timescale 1ns/10ps
module ctrl_model
(
  // Clock
  input  wire logic                clk,
  input  wire logic                clock_qualify_n,
  // Pins towards the port
  output      sram_port_pkg::cmd_t cmd,
  output      logic [35:0]         wd
);
  // ********
  // Write data pipe
  // ********
  logic [36:0] nxt   = 37'h0;
  logic [36:0] st1   = 37'h0;
  logic [36:0] st2   = 37'h0;
  logic [35:0] noise = 36'h5a3c96e1f;
  // A stretched cycle must not move the pipe, or data would land a beat early.
  always @(posedge clk)
    if (!clock_qualify_n)
    begin
      st1 <= nxt;
      st2 <= st1;
    end
  // Released lanes carry a pattern that changes every cycle, never the last word.
  always @(negedge clk)
  begin
    noise = ~{noise[34:0], noise[35]};
    wd = st2[36] ? st2[35:0] : noise;
  end
  task automatic put(input sram_port_pkg::cmd_t c, input logic w, input logic [35:0] d);
    cmd = c;
    nxt = {w, d};
  endtask
endmodule

// [tb/tb_sram_port.sv]
// Bench for the burst memory port: controller model, read-back queue, test port.
// Assumes the controller model and the design files are compiled first.
`timescale 1ns/10ps
module tb_sram_port;
  // ********
  // Signals
  // ********
  logic                clk = 1'b0, srst = 1'b1, clock_qualify_n = 1'b0, output_enable_n = 1'b0;
  logic                burst_mode = 1'b1, sleep_request = 1'b0, test_clk = 1'b0;
  logic                test_mode_sel = 1'b0, test_data_in = 1'b0, qedge = 1'b0;
  logic                act = 1'b0, isw = 1'b0, idle_before = 1'b1;
  logic [1:0]          beat = 2'h0;
  logic [17:0]         ba = 18'h0, ea, bb;
  logic [17:0]         adr [8];
  logic [31:0]         lfsr = 32'h9960d119;
  logic [35:0]         mem [logic [17:0]];
  logic [67:0]         exp_q [$];
  sram_port_pkg::cmd_t cmd;
  logic [35:0]         wd;
  logic [31:0]         dq_out;
  logic [3:0]          parity_lanes_out;
  logic                dq_oe, sleeping, test_data_out, test_mode_q;
  int                  cyc = 0, tick = 0, failures = 0, n_compared = 0;

  initial forever #4 clk = ~clk;

  ctrl_model i_ctrl (.clk(clk), .clock_qualify_n(clock_qualify_n), .cmd(cmd), .wd(wd));
  sram_port i_dut
  (
    .clk(clk), .srst(srst), .clock_qualify_n(clock_qualify_n),
    .chip_select_first_n(cmd.chip_select_first_n), .chip_select_second(cmd.chip_select_second),
    .chip_select_third_n(cmd.chip_select_third_n), .advance_or_load(cmd.advance_or_load),
    .write_n(cmd.write_n), .byte_write_sel_n(cmd.byte_write_sel_n), .addr(cmd.addr),
    .output_enable_n(output_enable_n), .burst_mode(burst_mode), .sleep_request(sleep_request),
    .dq_in(wd[31:0]), .parity_lanes_in(wd[35:32]), .dq_out(dq_out),
    .parity_lanes_out(parity_lanes_out), .dq_oe(dq_oe), .sleeping(sleeping), .test_clk(test_clk),
    .test_mode_sel(test_mode_sel), .test_data_in(test_data_in), .test_data_out(test_data_out),
    .test_mode_q(test_mode_q)
  );

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk_word(input logic [67:0] e, input logic [67:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_word({67'h0, e}, {67'h0, g});
  endtask
  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Only qualified edges count, so a stretched cycle moves no expectation.
  task automatic op(input logic [2:0] cs, input logic adv, input logic we, input logic [3:0] bw,
                    input logic [17:0] a, input logic [35:0] d);
    logic        w;
    logic [35:0] m;
    @(negedge clk);
    clock_qualify_n = 1'b0;
    if (!adv)
    begin
      act = cs == 3'b010;
      isw = !we;
      ba = a;
      beat = 2'h0;
    end
    else
      beat = beat + 2'h1;
    ea = {ba[17:2], burst_mode ? ba[1:0] ^ beat : ba[1:0] + beat};
    w = act && isw;
    for (int k = 0; k < 4; k++)
    begin
      m = (36'hff << (8 * k)) | (36'h1 << (32 + k));
      if (w && !bw[k])
        mem[ea] = (mem[ea] & ~m) | (d & m);
    end
    if (act && !isw && !idle_before && !output_enable_n)
      exp_q.push_back({32'(cyc + 5), mem[ea]});
    idle_before = !act;
    i_ctrl.put({cs, adv, we, bw, a}, w, d);
  endtask
  task automatic idle(input int n);
    repeat (n) op(3'b110, 1'b0, 1'b1, 4'hf, 18'h0, 36'h0);
  endtask
  task automatic rd(input logic [17:0] a);
    op(3'b010, 1'b0, 1'b1, 4'hf, a, 36'h0);
  endtask

  always @(posedge clk)
  begin
    qedge <= !clock_qualify_n;
    cyc <= cyc + int'(!clock_qualify_n);
    tick <= tick + 1;
    if (tick == 3000)
    begin
      failures++;
      give_verdict();
    end
  end
  always @(negedge clk)
    if (qedge && dq_oe === 1'b1)
      chk_word(exp_q.size() > 0 ? exp_q.pop_front() : 68'h0, {32'(cyc), parity_lanes_out, dq_out});

  initial
  begin
    i_ctrl.put({3'b110, 1'b0, 1'b1, 4'hf, 18'h0}, 1'b0, 36'h0);
    repeat (20) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk_bit(dq_oe, 1'b0);
    chk_bit(sleeping, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      adr[i] = 18'(rnd());
      op(3'b010, 1'b0, 1'b0, 4'h0, adr[i], 36'({rnd(), rnd()}));
    end
    for (int i = 0; i < 8; i++) rd(adr[i]);
    for (int i = 0; i < 4; i++) op(3'b010, 1'b0, 1'b0, ~(4'h1 << i), adr[i], 36'({rnd(), rnd()}));
    for (int i = 0; i < 4; i++) rd(adr[i]);
    rd(adr[4]);
    rd(adr[5]);
    repeat (3)
    begin
      @(negedge clk);
      clock_qualify_n = 1'b1;
      i_ctrl.put({3'b110, 1'b0, 1'b0, 4'h0, adr[0]}, 1'b0, 36'h0);
    end
    rd(adr[6]);
    rd(adr[7]);
    for (int j = 0; j < 3; j++)
    begin
      op(j == 0 ? 3'b110 : j == 1 ? 3'b000 : 3'b011, 1'b0, 1'b0, 4'h0, adr[0], 36'(rnd()));
      rd(adr[0]);
      rd(adr[0]);
    end
    idle(6);
    output_enable_n = 1'b1;
    for (int i = 1; i < 4; i++) rd(adr[i]);
    idle(6);
    output_enable_n = 1'b0;
    for (int m = 0; m < 2; m++)
      for (int s = 0; s < 4; s++)
      begin
        idle(4);
        burst_mode = m[0];
        bb = {16'(rnd()), s[1:0]};
        for (int k = 0; k < 4; k++) op(k == 0 ? 3'b010 : 3'(rnd()), k != 0, k == 0 ? 1'b0 : 1'(rnd()), 4'h0, bb, 36'(rnd()));
        for (int k = 0; k < 4; k++) op(k == 0 ? 3'b010 : 3'(rnd()), k != 0, k == 0 ? 1'b1 : 1'(rnd()), 4'hf, bb, 36'h0);
      end
    idle(4);
    sleep_request = 1'b1;
    for (int i = 0; i < 10 && sleeping !== 1'b1; i++) @(negedge clk);
    chk_bit(sleeping, 1'b1);
    sleep_request = 1'b0;
    for (int i = 0; i < 10 && sleeping !== 1'b0; i++) @(negedge clk);
    chk_bit(sleeping, 1'b0);
    idle(4);
    rd(adr[4]);
    rd(adr[4]);
    rd(adr[5]);
    idle(1);
    for (int i = 0; i < 8; i++)
    begin
      {test_mode_sel, test_data_in} = 2'(rnd());
      #3 test_clk = 1'b1;
      #3 chk_bit(test_mode_q, test_mode_sel);
      test_clk = 1'b0;
      #3 chk_bit(test_data_out, test_data_in);
    end
    idle(8);
    chk_bit(exp_q.size() == 0, 1'b1);
    give_verdict();
  end
endmodule
